/* File: src/dptc_cfg.svh */
// Offsets, field positions, reset values and scaling constants
// Assumes a 24-bit register port addressed by an 8-bit byte index
//
// What this block does
// [RULE1] Supplementary frames add a signed 13-bit trim to the phase
// [RULE2] Correction is offset plus two slope-times-temperature-delta terms
// [RULE3] Both slope coefficients are 17-bit signed values
// [RULE4] Coefficients shift left by precision minus eight; precision resets to 8
// [RULE5] Software keeps the saturate select bit at one; it resets to one
// [RULE6] Thermal-off bit removes both temperature terms
// [RULE7] Offset-off bit removes the frame trim from the correction
// [RULE8] Spare byte in reference register, read-write, reset zero, no effect
// [RULE9] Base frames add their own signed 13-bit trim to the phase
// [RULE10] Emitter temperature reading is an 8-bit signed value
// [RULE11] 8-bit references are subtracted from readings before multiplying
// [RULE12] Upper bits of the supplementary trim register are ignored
`ifndef DPTC_CFG_SVH
`define DPTC_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DPTC_OFS_SUPP 8'hf5
`define DPTC_OFS_CTRL 8'hf6
`define DPTC_OFS_EMIT 8'hf7
`define DPTC_OFS_TREF 8'hf8
`define DPTC_OFS_BASE 8'hf9
`define DPTC_OFS_STAT 8'hfa

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DPTC_RST_SUPP 24'h000000
`define DPTC_RST_CTRL 24'h880000
`define DPTC_RST_EMIT 24'h000000
`define DPTC_RST_TREF 24'h000000
`define DPTC_RST_BASE 24'h080000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DPTC_TRIM_HI 12
`define DPTC_COEF_HI 16
`define DPTC_PREC_HI 23
`define DPTC_PREC_LO 20
`define DPTC_SAT_BIT 19
`define DPTC_THOFF_BIT 18
`define DPTC_OFSOFF_BIT 17
`define DPTC_SPARE_HI 23
`define DPTC_SPARE_LO 16
`define DPTC_EREF_HI 15
`define DPTC_EREF_LO 8
`define DPTC_DREF_HI 7
`define DPTC_FLIP_BIT 19
`define DPTC_CLIP_BIT 16

// ----------------------------------------
// Scaling
// ----------------------------------------
`define DPTC_PREC_UNITY 4'h8
`define DPTC_COEF_FRAC 8

`endif

/* File: src/dptc_pkg.sv */
// Shared types of the phase correction datapath
// Assumes dptc_cfg.svh for the numeric constants
package dptc_pkg;
	typedef logic signed [12:0] dptc_trim_t;
	typedef logic signed [16:0] dptc_coef_t;
	typedef logic signed [23:0] dptc_scoef_t;
	typedef logic signed [8:0] dptc_delta_t;
	typedef logic signed [32:0] dptc_term_t;
	typedef logic signed [35:0] dptc_sum_t;
endpackage : dptc_pkg

/* File: src/dptc_top.sv */
// Phase trim and temperature correction datapath with its registers
// Assumes phase and temperature inputs come from logic on REF_CLK
`timescale 1ns/1ps
`include "dptc_cfg.svh"

module dptc_top #(
	parameter int PW = 12
) (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic [7:0] ADDR,
	input wire logic [23:0] WR_DATA,
	input wire logic WR_EN,
	input wire logic RD_EN,
	output logic [23:0] RD_DATA,
	input wire logic [PW-1:0] PHASE_IN,
	input wire logic PHASE_VALID,
	input wire logic SUPP_FRAME,
	input wire logic [7:0] EMITTER_TEMP,
	input wire logic [7:0] DIE_TEMP,
	output logic [PW-1:0] PHASE_OUT,
	output logic PHASE_OUT_VALID
);

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [23:0] supp_reg;
	logic [23:0] ctrl_reg;
	logic [23:0] emit_reg;
	logic [23:0] tref_reg;
	logic [23:0] base_reg;
	logic clip_reg;

	wire wr_supp = WR_EN && ADDR == `DPTC_OFS_SUPP;
	wire wr_ctrl = WR_EN && ADDR == `DPTC_OFS_CTRL;
	wire wr_emit = WR_EN && ADDR == `DPTC_OFS_EMIT;
	wire wr_tref = WR_EN && ADDR == `DPTC_OFS_TREF;
	wire wr_base = WR_EN && ADDR == `DPTC_OFS_BASE;

	// [RULE12] Upper trim bits dropped
	wire [23:0] supp_next = {11'h000, WR_DATA[`DPTC_TRIM_HI:0]};
	wire [23:0] base_next = {4'h0, WR_DATA[`DPTC_FLIP_BIT], 6'h00,
		WR_DATA[`DPTC_TRIM_HI:0]};
	wire [23:0] emit_next = {7'h00, WR_DATA[`DPTC_COEF_HI:0]};

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			supp_reg <= `DPTC_RST_SUPP;
			ctrl_reg <= `DPTC_RST_CTRL;
			emit_reg <= `DPTC_RST_EMIT;
			tref_reg <= `DPTC_RST_TREF;
			base_reg <= `DPTC_RST_BASE;
		end else begin
			if (wr_supp) supp_reg <= supp_next;
			if (wr_ctrl) ctrl_reg <= WR_DATA;
			if (wr_emit) emit_reg <= emit_next;
			// [RULE8] Spare byte stored
			if (wr_tref) tref_reg <= WR_DATA;
			if (wr_base) base_reg <= base_next;
		end
	end

	wire [23:0] stat_word = {7'h00, clip_reg, EMITTER_TEMP, DIE_TEMP};
	wire [23:0] rd_next =
		ADDR == `DPTC_OFS_SUPP ? supp_reg :
		ADDR == `DPTC_OFS_CTRL ? ctrl_reg :
		ADDR == `DPTC_OFS_EMIT ? emit_reg :
		ADDR == `DPTC_OFS_TREF ? tref_reg :
		ADDR == `DPTC_OFS_BASE ? base_reg :
		ADDR == `DPTC_OFS_STAT ? stat_word : 24'h000000;

	always_ff @(posedge REF_CLK) begin
		if (RST) RD_DATA <= 24'h000000;
		else if (RD_EN) RD_DATA <= rd_next;
		else RD_DATA <= 24'h000000;
	end

	// ----------------------------------------
	// Control fields
	// ----------------------------------------
	wire [3:0] prec = ctrl_reg[`DPTC_PREC_HI:`DPTC_PREC_LO];
	wire sat_sel = ctrl_reg[`DPTC_SAT_BIT];
	wire therm_off = ctrl_reg[`DPTC_THOFF_BIT];
	wire ofs_off = ctrl_reg[`DPTC_OFSOFF_BIT];
	wire [7:0] spare_byte = tref_reg[`DPTC_SPARE_HI:`DPTC_SPARE_LO];
	wire [7:0] wr_spare = WR_DATA[`DPTC_SPARE_HI:`DPTC_SPARE_LO];
	wire [7:0] emit_ref = tref_reg[`DPTC_EREF_HI:`DPTC_EREF_LO];
	wire [7:0] die_ref = tref_reg[`DPTC_DREF_HI:0];
	// [RULE3] Signed slope fields
	wire dptc_pkg::dptc_coef_t die_coef = ctrl_reg[`DPTC_COEF_HI:0];
	wire dptc_pkg::dptc_coef_t emit_coef = emit_reg[`DPTC_COEF_HI:0];
	wire dptc_pkg::dptc_trim_t supp_trim = supp_reg[`DPTC_TRIM_HI:0];
	wire dptc_pkg::dptc_trim_t base_trim = base_reg[`DPTC_TRIM_HI:0];

	// [RULE4] Precision scaling
	function automatic dptc_pkg::dptc_scoef_t scale_coef(
		input dptc_pkg::dptc_coef_t c,
		input logic [3:0] p
	);
		dptc_pkg::dptc_scoef_t ext;
		ext = 24'(c);
		if (p >= `DPTC_PREC_UNITY) return ext <<< (p - `DPTC_PREC_UNITY);
		else return ext >>> (`DPTC_PREC_UNITY - p);
	endfunction : scale_coef

	// ----------------------------------------
	// Stage 1: trims and temperature terms
	// ----------------------------------------
	// [RULE10] Signed temperature readings
	wire signed [7:0] emit_t = EMITTER_TEMP;
	wire signed [7:0] die_t = DIE_TEMP;
	// [RULE11] Reference subtracted first
	wire dptc_pkg::dptc_delta_t emit_dt = 9'(emit_t) - 9'($signed(emit_ref));
	wire dptc_pkg::dptc_delta_t die_dt = 9'(die_t) - 9'($signed(die_ref));

	wire dptc_pkg::dptc_scoef_t emit_sc = scale_coef(emit_coef, prec);
	wire dptc_pkg::dptc_scoef_t die_sc = scale_coef(die_coef, prec);
	wire dptc_pkg::dptc_term_t emit_prod = 33'(emit_sc) * 33'(emit_dt);
	wire dptc_pkg::dptc_term_t die_prod = 33'(die_sc) * 33'(die_dt);
	wire dptc_pkg::dptc_term_t emit_term = emit_prod >>> `DPTC_COEF_FRAC;
	wire dptc_pkg::dptc_term_t die_term = die_prod >>> `DPTC_COEF_FRAC;

	// [RULE1] [RULE9] Trim by frame kind
	wire dptc_pkg::dptc_trim_t trim_sel = SUPP_FRAME ? supp_trim : base_trim;
	// [RULE7] Offset removed when disabled
	wire dptc_pkg::dptc_trim_t trim_next = ofs_off ? 13'sh0000 : trim_sel;
	// [RULE6] Thermal terms removed when disabled
	wire dptc_pkg::dptc_term_t emit_next_t = therm_off ? '0 : emit_term;
	wire dptc_pkg::dptc_term_t die_next_t = therm_off ? '0 : die_term;

	logic [PW-1:0] phase_s1_reg;
	dptc_pkg::dptc_trim_t trim_s1_reg;
	dptc_pkg::dptc_term_t emit_s1_reg;
	dptc_pkg::dptc_term_t die_s1_reg;
	logic valid_s1_reg;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			phase_s1_reg <= '0;
			trim_s1_reg <= '0;
			emit_s1_reg <= '0;
			die_s1_reg <= '0;
			valid_s1_reg <= 1'b0;
		end else begin
			valid_s1_reg <= PHASE_VALID;
			if (PHASE_VALID) begin
				phase_s1_reg <= PHASE_IN;
				trim_s1_reg <= trim_next;
				emit_s1_reg <= emit_next_t;
				die_s1_reg <= die_next_t;
			end
		end
	end

	// ----------------------------------------
	// Stage 2: sum and clip
	// ----------------------------------------
	// [RULE2] Phase plus full correction
	wire dptc_pkg::dptc_sum_t sum_wide = 36'($signed({1'b0, phase_s1_reg}))
		+ 36'(trim_s1_reg) + 36'(emit_s1_reg) + 36'(die_s1_reg);
	wire dptc_pkg::dptc_sum_t max_val = 36'((1 << PW) - 1);
	wire under = sum_wide < 0;
	wire over = sum_wide > max_val;
	// [RULE5] Saturate path relies on select high
	wire [PW-1:0] clip_val = under ? '0 : over ? '1 : sum_wide[PW-1:0];
	wire [PW-1:0] out_next = sat_sel ? clip_val : sum_wide[PW-1:0];

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			PHASE_OUT <= '0;
			PHASE_OUT_VALID <= 1'b0;
			clip_reg <= 1'b0;
		end else begin
			PHASE_OUT_VALID <= valid_s1_reg;
			if (valid_s1_reg) begin
				PHASE_OUT <= out_next;
				clip_reg <= sat_sel && (under || over);
			end
		end
	end

	// ----------------------------------------
	// Assertions: datapath timing
	// ----------------------------------------
	a_out_latency: assert property (@(posedge REF_CLK) // [RULE2]
		disable iff (RST) PHASE_VALID |-> ##2 PHASE_OUT_VALID)
		else $error("Output valid not two cycles after input");

	a_out_quiet: assert property (@(posedge REF_CLK) // [RULE2]
		disable iff (RST) !PHASE_VALID |-> ##2 !PHASE_OUT_VALID)
		else $error("Output valid without an input two cycles before");

	// Between results the output word must not move
	a_out_hold: assert property (@(posedge REF_CLK) // [RULE2]
		disable iff (RST) !valid_s1_reg |=> $stable(PHASE_OUT))
		else $error("Output changed without a result");

	// ----------------------------------------
	// Assertions: frame trims
	// ----------------------------------------
	a_supp_trim: assert property (@(posedge REF_CLK) // [RULE1]
		disable iff (RST) PHASE_VALID && SUPP_FRAME && !ofs_off |=>
		trim_s1_reg == $past(supp_trim))
		else $error("Supplementary trim not applied");

	a_base_trim: assert property (@(posedge REF_CLK) // [RULE9]
		disable iff (RST) PHASE_VALID && !SUPP_FRAME && !ofs_off |=>
		trim_s1_reg == $past(base_trim))
		else $error("Base trim not applied");

	a_offset_off: assert property (@(posedge REF_CLK) // [RULE7]
		disable iff (RST) PHASE_VALID && ofs_off |=> trim_s1_reg == 0)
		else $error("Offset applied while disabled");

	a_trim_hold: assert property (@(posedge REF_CLK) // [RULE1]
		disable iff (RST) !PHASE_VALID |=> $stable(trim_s1_reg))
		else $error("Stage trim changed without an input");

	// ----------------------------------------
	// Assertions: temperature terms
	// ----------------------------------------
	// Products at unity precision, the reference for the scaling checks
	wire dptc_pkg::dptc_term_t emit_unity =
		(33'(emit_coef) * 33'(emit_dt)) >>> `DPTC_COEF_FRAC;
	wire dptc_pkg::dptc_term_t die_unity =
		(33'(die_coef) * 33'(die_dt)) >>> `DPTC_COEF_FRAC;

	a_thermal_off: assert property (@(posedge REF_CLK) // [RULE6]
		disable iff (RST) PHASE_VALID && therm_off |=>
		emit_s1_reg == 0 && die_s1_reg == 0)
		else $error("Thermal terms applied while disabled");

	a_unity_prec: assert property (@(posedge REF_CLK) // [RULE4]
		disable iff (RST)
		PHASE_VALID && !therm_off && prec == `DPTC_PREC_UNITY |=>
		emit_s1_reg == $past(emit_unity))
		else $error("Unity precision changed coefficient");

	a_die_unity: assert property (@(posedge REF_CLK) // [RULE3]
		disable iff (RST)
		PHASE_VALID && !therm_off && prec == `DPTC_PREC_UNITY |=>
		die_s1_reg == $past(die_unity))
		else $error("Die term wrong at unity precision");

	a_prec_up: assert property (@(posedge REF_CLK) // [RULE4]
		disable iff (RST) prec == 4'h9 |-> emit_sc == 24'(emit_coef) * 24'sd2)
		else $error("Precision nine did not double the coefficient");

	a_prec_down: assert property (@(posedge REF_CLK) // [RULE4]
		disable iff (RST) prec == 4'h7 |-> emit_sc == 24'(emit_coef) >>> 1)
		else $error("Precision seven did not halve the coefficient");

	// A negative reading less a positive reference stays negative
	a_delta_sign: assert property (@(posedge REF_CLK) // [RULE10]
		disable iff (RST) EMITTER_TEMP[7] && !emit_ref[7] |->
		emit_dt[8])
		else $error("Emitter reading not signed");

	// A positive reading less a negative reference stays positive
	a_die_delta: assert property (@(posedge REF_CLK) // [RULE11]
		disable iff (RST) !DIE_TEMP[7] && die_ref[7] |->
		!die_dt[8])
		else $error("Die reference not subtracted as signed");

	// ----------------------------------------
	// Assertions: saturation
	// ----------------------------------------
	a_clip_low: assert property (@(posedge REF_CLK) // [RULE5]
		disable iff (RST) valid_s1_reg && sat_sel && under |=> PHASE_OUT == 0)
		else $error("Negative sum not clipped to zero");

	a_clip_high: assert property (@(posedge REF_CLK) // [RULE5]
		disable iff (RST) valid_s1_reg && sat_sel && over |=> &PHASE_OUT)
		else $error("Large sum not clipped to full scale");

	a_clip_flag: assert property (@(posedge REF_CLK) // [RULE5]
		disable iff (RST) valid_s1_reg && !under && !over |=> !clip_reg)
		else $error("Clip status set for an in-range result");

	// ----------------------------------------
	// Assertions: register port
	// ----------------------------------------
	a_spare_byte: assert property (@(posedge REF_CLK) // [RULE8]
		disable iff (RST) wr_tref |=> spare_byte == $past(wr_spare))
		else $error("Spare byte not stored");

	a_spare_read: assert property (@(posedge REF_CLK) // [RULE8]
		disable iff (RST) RD_EN && ADDR == `DPTC_OFS_TREF |=>
		RD_DATA[`DPTC_SPARE_HI:`DPTC_SPARE_LO] == $past(spare_byte))
		else $error("Spare byte not read back");

	a_trim_upper: assert property (@(posedge REF_CLK) // [RULE12]
		disable iff (RST) RD_EN && ADDR == `DPTC_OFS_SUPP |=>
		RD_DATA[23:13] == 11'h000)
		else $error("Trim upper bits not zero");

	// ----------------------------------------
	// Cover points
	// ----------------------------------------
	c_supp_frame: cover property (@(posedge REF_CLK) disable iff (RST)
		PHASE_VALID && SUPP_FRAME ##2 PHASE_OUT_VALID);
	c_clip_high: cover property (@(posedge REF_CLK) disable iff (RST)
		valid_s1_reg && sat_sel && over);
	c_clip_low: cover property (@(posedge REF_CLK) disable iff (RST)
		valid_s1_reg && sat_sel && under);
	c_thermal_on: cover property (@(posedge REF_CLK) disable iff (RST)
		PHASE_VALID && !therm_off && emit_term != 0);
	c_offset_off: cover property (@(posedge REF_CLK) disable iff (RST)
		PHASE_VALID && ofs_off);

endmodule : dptc_top

/* File: tb/tb_top.sv */
// Self-checking bench for the phase correction datapath
// Assumes dptc_top with PW of 12 and its register port on REF_CLK
`timescale 1ns/1ps
`include "dptc_cfg.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected t=%0t got %h exp %h", $time, g, e); end end

module tb_top;
	logic clk = 0, rst = 1, wr_en = 0, rd_en = 0, pv = 0, supp = 0;
	logic [7:0] addr = 0, et = 0, dt = 0;
	logic [23:0] wd = 0, rdata;
	logic [11:0] pin = 0, pout;
	logic povld;
	// Mirror of f5..f9, starts at the reset values
	logic [23:0] rm [5] = '{24'h0, 24'h880000, 24'h0, 24'h0, 24'h080000};
	int fail_count = 0, checks = 0;

	always #12.5 clk = ~clk;

	dptc_top #(.PW(12)) i_dut (.REF_CLK(clk), .RST(rst), .ADDR(addr),
		.WR_DATA(wd), .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rdata),
		.PHASE_IN(pin), .PHASE_VALID(pv), .SUPP_FRAME(supp),
		.EMITTER_TEMP(et), .DIE_TEMP(dt), .PHASE_OUT(pout),
		.PHASE_OUT_VALID(povld));

	// ----------------------------------------
	// Bus and model helpers
	// ----------------------------------------
	function automatic logic [23:0] msk(input logic [7:0] a);
		case (a)
			8'hf5: return 24'h001fff;
			8'hf7: return 24'h01ffff;
			8'hf9: return 24'h081fff;
			default: return 24'hffffff;
		endcase
	endfunction : msk

	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr_en <= 1'b0;
		if (a >= 8'hf5 && a <= 8'hf9) rm[a - 8'hf5] = d & msk(a);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [23:0] q);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 q = rdata;
	endtask : rd

	function automatic longint scl(input logic [16:0] c);
		int pr;
		longint v;
		pr = rm[1][23:20];
		v = longint'(signed'(c));
		return pr >= 8 ? v <<< (pr - 8) : v >>> (8 - pr);
	endfunction : scl

	function automatic logic [11:0] model(input logic [11:0] p, input logic s);
		longint tr, te, td, sum;
		tr = s ? longint'(signed'(rm[0][12:0])) : longint'(signed'(rm[4][12:0]));
		te = (scl(rm[2][16:0]) * (longint'(signed'(et))
			- longint'(signed'(rm[3][15:8])))) >>> 8;
		td = (scl(rm[1][16:0]) * (longint'(signed'(dt))
			- longint'(signed'(rm[3][7:0])))) >>> 8;
		sum = longint'(p) + (rm[1][17] ? 0 : tr) + (rm[1][18] ? 0 : te + td);
		if (!rm[1][19]) return sum[11:0];
		return sum < 0 ? 12'h0 : (sum > 4095 ? 12'hfff : sum[11:0]);
	endfunction : model

	task automatic ph(input logic [11:0] p, input logic s);
		logic [11:0] e;
		@(posedge clk);
		pv <= 1'b1;
		pin <= p;
		supp <= s;
		@(posedge clk);
		pv <= 1'b0;
		e = model(p, s);
		// Result stands in the second cycle after the sampling edge
		@(posedge clk);
		#1;
		`CHK(povld, 1'b1)
		`CHK(pout, e)
		@(posedge clk);
		#1;
		`CHK(povld, 1'b0)
	endtask : ph

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		logic [23:0] q;
		for (int i = 0; i < 5; i++) begin
			rd(8'hf5 + 8'(i), q);
			`CHK(q, rm[i])
		end
		// Read data stand one cycle only
		@(posedge clk);
		#1;
		`CHK(rdata, 24'h0)
		rd(8'hf4, q);
		`CHK(q, 24'h0)
	endtask : t_reset

	task automatic t_regs;
		logic [23:0] q;
		foreach (rm[i]) begin
			wr(8'hf5 + 8'(i), 24'hffffff);
			rd(8'hf5 + 8'(i), q);
			`CHK(q, rm[i])
			wr(8'hf5 + 8'(i), 24'h5ac3a5);
			rd(8'hf5 + 8'(i), q);
			`CHK(q, rm[i])
		end
	endtask : t_regs

	// Trims of +2047 and -2048, clipping at each end
	task automatic t_trim;
		logic [23:0] q;
		wr(`DPTC_OFS_CTRL, 24'h880000);
		wr(`DPTC_OFS_EMIT, 24'h0);
		// Upper trim bits written as zero
		wr(`DPTC_OFS_SUPP, 24'h0007ff);
		wr(`DPTC_OFS_BASE, 24'h081800);
		for (int k = 0; k < 3; k++) begin
			ph(12'h700 * k[11:0], 1'b1);
			ph(12'h700 * k[11:0], 1'b0);
		end
		// A clipped result shows in the status word
		ph(12'he00, 1'b1);
		rd(`DPTC_OFS_STAT, q);
		`CHK(q, {7'h00, 1'b1, et, dt})
		wr(`DPTC_OFS_CTRL, 24'h8a0000);
		ph(12'h400, 1'b1);
		ph(12'h400, 1'b0);
		rd(`DPTC_OFS_STAT, q);
		`CHK(q, {7'h00, 1'b0, et, dt})
	endtask : t_trim

	// Both temperature terms over precisions and the thermal-off bit
	task automatic t_temp;
		wr(`DPTC_OFS_SUPP, 24'h000010);
		wr(`DPTC_OFS_EMIT, 24'h000180);
		wr(`DPTC_OFS_TREF, 24'h3c19f6);
		dt <= 8'h05;
		for (int j = 0; j < 2; j++) begin
			et <= j ? 8'hd8 : 8'h3c;
			for (int pr = 7; pr < 10; pr++) begin
				for (int th = 0; th < 2; th++) begin
					wr(`DPTC_OFS_CTRL, {4'(pr), 1'b1, 1'(th), 1'b0, 17'h1ffc0});
					ph(12'h800, 1'b1);
					ph(12'h100, 1'b0);
				end
			end
		end
	endtask : t_temp

	task automatic print_verdict;
		if (fail_count == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_regs;
		t_trim;
		t_temp;
		print_verdict;
	end

	initial begin
		#1ms;
		fail_count++;
		print_verdict;
	end
endmodule : tb_top
